//--- verilog/gate_driver_config_regs.sv
// gate-driver configuration registers, overcurrent fault handler, interrupt
// assumes an APB3 master on ref_clk and an asynchronous overcurrent comparator pin
//
// How it works
// [R01] the overcurrent level bit picks the 9 A trip when clear and 13 A when set, reset 0.
// [R02] the two-bit fault mode resets to 1, code 0 latches, code 1 retries after 500 ms.
// [R03] the sense gain code is only in force while dynamic gain is off.
// [R04] bit 30 of the second word turns delay compensation on, reset 0.
// [R05] bits 29 to 26 hold the delay target code, 0 automatic, 1 to 9 fixed steps.
// [R06] bit 24 disables regulator sequencing, resets to 1 and is cleared by writing one.
// [R07] bit 23 picks the 150 mA regulator limit when set, 600 mA when clear.
// [R08] bits 22 to 21 pick the regulator voltage and reset to code 1.
// [R09] bit 20 turns the regulator off when set, reset 0.
// [R10] bits 19 to 17 hold the low-side minimum on-time code.
// [R11] software leaves unlisted algorithm offsets alone.
// [R12] the two algorithm words decode at A0h and A2h.
// [R13] an overcurrent must persist for the deglitch time before the fault mode acts.
// [R14] reserved bits read zero and ignore writes, fields reset to their values.
// [R15] a latched fault holds the outputs off until cleared, a retry fault ends itself.
`timescale 1ns/1ps
module gate_driver_config_regs #(
    parameter int unsigned retry_cycles = gate_driver_pkg::RETRY_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic overcurrent_trip,
    input wire logic dynamic_sense_gain_enable,
    output logic overcurrent_level_sel,
    output logic [1:0] overcurrent_fault_mode,
    output logic [1:0] overcurrent_deglitch_sel,
    output logic [1:0] sense_amp_gain_sel,
    output logic sense_gain_fixed_active,
    output logic delay_comp_enable,
    output logic [3:0] delay_target_sel,
    output logic regulator_sequencing_disable,
    output logic regulator_current_limit_sel,
    output logic [1:0] regulator_voltage_sel,
    output logic regulator_disable,
    output logic [2:0] low_side_min_on_sel,
    output logic [31:0] algo_config_one,
    output logic [31:0] algo_config_two,
    output logic outputs_disable,
    output logic irq
);
    function automatic logic addr_is(input logic [11:0] a, input logic [9:0] idx);
        return (a[1:0] == 2'b00) && (a[11:2] == idx);
    endfunction

    // least time, so round up to whole cycles
    function automatic logic [gate_driver_pkg::DEG_CNT_W-1:0] deglitch_cycles(
        input logic [1:0] code);
        int unsigned ns;
        case (code)
            2'h0: ns = gate_driver_pkg::DEG_NS_0;
            2'h1: ns = gate_driver_pkg::DEG_NS_1;
            2'h2: ns = gate_driver_pkg::DEG_NS_2;
            default: ns = gate_driver_pkg::DEG_NS_3;
        endcase
        return gate_driver_pkg::DEG_CNT_W'((ns * gate_driver_pkg::CLK_MHZ + 999) / 1000);
    endfunction

    logic [31:0] cfg1_reg, cfg1_next, cfg2_reg, cfg2_next;
    logic [31:0] algo1_reg, algo1_next, algo2_reg, algo2_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic [gate_driver_pkg::IRQ_W-1:0] status_reg, status_next, mask_reg, mask_next;
    logic irq_reg, irq_next, gain_fixed_reg, gain_fixed_next;
    logic setup, access_done, wr, rd, fault_clear;
    logic [31:0] rdata;
    logic rerr;
    logic [gate_driver_pkg::IRQ_W-1:0] events, status_clr;

    gate_driver_pkg::fault_state_t state_reg, state_next;
    logic oc_meta_reg, oc_sync_reg;
    logic [gate_driver_pkg::DEG_CNT_W-1:0] deg_reg, deg_next, deg_limit;
    logic [gate_driver_pkg::RETRY_CNT_W-1:0] retry_reg, retry_next;
    logic disable_reg, disable_next;

    always_comb begin
        setup = psel && !penable;
        access_done = psel && penable && pready_reg;
        wr = access_done && pwrite && !pslverr_reg;
        rd = access_done && !pwrite && !pslverr_reg;
        rdata = 32'h00000000;
        rerr = 1'b0;
        // [R12] algorithm word decode
        if (addr_is(paddr, gate_driver_pkg::IDX_ALGO_ONE)) begin
            rdata = algo1_reg;
        end else if (addr_is(paddr, gate_driver_pkg::IDX_ALGO_TWO)) begin
            rdata = algo2_reg;
        end else if (addr_is(paddr, gate_driver_pkg::IDX_CFG_FIRST)) begin
            rdata = cfg1_reg;
        end else if (addr_is(paddr, gate_driver_pkg::IDX_CFG_SECOND)) begin
            rdata = cfg2_reg;
        end else if (addr_is(paddr, gate_driver_pkg::IDX_IRQ_STATUS)) begin
            rdata = {{(32 - gate_driver_pkg::IRQ_W){1'b0}}, status_reg};
        end else if (addr_is(paddr, gate_driver_pkg::IDX_IRQ_MASK)) begin
            rdata = {{(32 - gate_driver_pkg::IRQ_W){1'b0}}, mask_reg};
        end else if (addr_is(paddr, gate_driver_pkg::IDX_FAULT)) begin
            rdata[gate_driver_pkg::FAULT_ACTIVE_BIT] = state_reg != gate_driver_pkg::FAULT_IDLE;
            rdata[gate_driver_pkg::FAULT_LATCHED_BIT] =
                state_reg == gate_driver_pkg::FAULT_LATCHED;
        end else begin
            rerr = 1'b1;
        end
        // answer is prepared in setup, shown during the single access cycle
        pready_next = setup;
        pslverr_next = setup ? rerr : 1'b0;
        prdata_next = setup ? (pwrite ? 32'h00000000 : rdata) : prdata_reg;

        // [R14] reserved bits masked off on write
        cfg1_next = cfg1_reg;
        cfg2_next = cfg2_reg;
        algo1_next = algo1_reg;
        algo2_next = algo2_reg;
        mask_next = mask_reg;
        if (wr && addr_is(paddr, gate_driver_pkg::IDX_CFG_FIRST)) begin
            cfg1_next = pwdata & gate_driver_pkg::CFG1_WMASK;
        end
        // [R06] write one clears sequencing disable
        if (wr && addr_is(paddr, gate_driver_pkg::IDX_CFG_SECOND)) begin
            cfg2_next = (pwdata & gate_driver_pkg::CFG2_RW_MASK)
                      | (cfg2_reg & gate_driver_pkg::CFG2_W1C_MASK & ~pwdata);
        end
        if (wr && addr_is(paddr, gate_driver_pkg::IDX_ALGO_ONE)) begin
            algo1_next = pwdata & gate_driver_pkg::ALGO1_WMASK;
        end
        if (wr && addr_is(paddr, gate_driver_pkg::IDX_ALGO_TWO)) begin
            algo2_next = pwdata & gate_driver_pkg::ALGO2_WMASK;
        end
        if (wr && addr_is(paddr, gate_driver_pkg::IDX_IRQ_MASK)) begin
            mask_next = pwdata[gate_driver_pkg::IRQ_W-1:0];
        end
        fault_clear = wr && addr_is(paddr, gate_driver_pkg::IDX_FAULT)
                    && pwdata[gate_driver_pkg::FAULT_CLEAR_BIT];

        // only bits actually returned are cleared, so a late event survives
        status_clr = '0;
        if (rd && addr_is(paddr, gate_driver_pkg::IDX_IRQ_STATUS)) begin
            status_clr = prdata_reg[gate_driver_pkg::IRQ_W-1:0];
        end
        status_next = (status_reg & ~status_clr) | events;
        irq_next = |(status_next & mask_next);
        // [R03] fixed gain only without dynamic gain
        gain_fixed_next = !dynamic_sense_gain_enable;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg1_reg <= gate_driver_pkg::CFG1_RESET;
            cfg2_reg <= gate_driver_pkg::CFG2_RESET;
            algo1_reg <= gate_driver_pkg::ALGO_RESET;
            algo2_reg <= gate_driver_pkg::ALGO_RESET;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            status_reg <= '0;
            mask_reg <= '0;
            irq_reg <= 1'b0;
            gain_fixed_reg <= 1'b0;
        end else begin
            cfg1_reg <= cfg1_next;
            cfg2_reg <= cfg2_next;
            algo1_reg <= algo1_next;
            algo2_reg <= algo2_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            gain_fixed_reg <= gain_fixed_next;
        end
    end

    always_comb begin
        deg_limit = deglitch_cycles(cfg1_reg[gate_driver_pkg::CFG1_DEG_LSB +: 2]);
        state_next = state_reg;
        deg_next = '0;
        retry_next = retry_reg;
        events = '0;
        case (state_reg)
            gate_driver_pkg::FAULT_IDLE: begin
                // [R13] trip only after deglitch time
                if (oc_sync_reg) begin
                    if (deg_reg == deg_limit - 1'b1) begin
                        events[gate_driver_pkg::IRQ_OC_FAULT] = 1'b1;
                        retry_next = '0;
                        // [R02] reserved codes latch, the safer choice
                        if (cfg1_reg[gate_driver_pkg::CFG1_MODE_LSB +: 2]
                            == gate_driver_pkg::MODE_RETRY) begin
                            state_next = gate_driver_pkg::FAULT_RETRY;
                        end else begin
                            state_next = gate_driver_pkg::FAULT_LATCHED;
                        end
                    end else begin
                        deg_next = deg_reg + 1'b1;
                    end
                end
            end
            gate_driver_pkg::FAULT_RETRY: begin
                // [R15] retry interval ends the fault
                if (retry_reg == gate_driver_pkg::RETRY_CNT_W'(retry_cycles - 1)) begin
                    state_next = gate_driver_pkg::FAULT_IDLE;
                    events[gate_driver_pkg::IRQ_RETRY_DONE] = 1'b1;
                end else begin
                    retry_next = retry_reg + 1'b1;
                end
            end
            gate_driver_pkg::FAULT_LATCHED: begin
                // [R15] held until software clears
                if (fault_clear) begin
                    state_next = gate_driver_pkg::FAULT_IDLE;
                end
            end
            default: state_next = gate_driver_pkg::FAULT_IDLE;
        endcase
        disable_next = state_next != gate_driver_pkg::FAULT_IDLE;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            oc_meta_reg <= 1'b0;
            oc_sync_reg <= 1'b0;
            state_reg <= gate_driver_pkg::FAULT_IDLE;
            deg_reg <= '0;
            retry_reg <= '0;
            disable_reg <= 1'b0;
        end else begin
            oc_meta_reg <= overcurrent_trip;
            oc_sync_reg <= oc_meta_reg;
            state_reg <= state_next;
            deg_reg <= deg_next;
            retry_reg <= retry_next;
            disable_reg <= disable_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    // [R01] level select straight from the register
    assign overcurrent_level_sel = cfg1_reg[gate_driver_pkg::CFG1_LVL];
    assign overcurrent_fault_mode = cfg1_reg[gate_driver_pkg::CFG1_MODE_LSB +: 2];
    assign overcurrent_deglitch_sel = cfg1_reg[gate_driver_pkg::CFG1_DEG_LSB +: 2];
    assign sense_amp_gain_sel = cfg1_reg[gate_driver_pkg::CFG1_GAIN_LSB +: 2];
    assign sense_gain_fixed_active = gain_fixed_reg;
    // [R04] [R05] [R07] [R08] [R09] [R10] driver fields out
    assign delay_comp_enable = cfg2_reg[gate_driver_pkg::CFG2_DCOMP];
    assign delay_target_sel = cfg2_reg[gate_driver_pkg::CFG2_TDLY_LSB +: 4];
    assign regulator_sequencing_disable = cfg2_reg[gate_driver_pkg::CFG2_SEQ];
    assign regulator_current_limit_sel = cfg2_reg[gate_driver_pkg::CFG2_CL];
    assign regulator_voltage_sel = cfg2_reg[gate_driver_pkg::CFG2_VSEL_LSB +: 2];
    assign regulator_disable = cfg2_reg[gate_driver_pkg::CFG2_BDIS];
    assign low_side_min_on_sel = cfg2_reg[gate_driver_pkg::CFG2_MINON_LSB +: 3];
    assign algo_config_one = algo1_reg;
    assign algo_config_two = algo2_reg;
    assign outputs_disable = disable_reg;
    assign irq = irq_reg;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    logic wr_cfg1, wr_cfg2;
    assign wr_cfg1 = wr && addr_is(paddr, gate_driver_pkg::IDX_CFG_FIRST);
    assign wr_cfg2 = wr && addr_is(paddr, gate_driver_pkg::IDX_CFG_SECOND);
    sequence s_setup_at(logic [9:0] idx);
        psel && !penable && !pwrite && addr_is(paddr, idx);
    endsequence
    sequence s_access_seen;
        psel && penable && pready;
    endsequence

    property p_level_write;
        wr_cfg1 |=> overcurrent_level_sel == $past(pwdata[10]);
    endproperty
    a_level_write: assert property (p_level_write) else $error("level bit not stored"); // [R01]

    property p_mode_write;
        wr_cfg1 |=> overcurrent_fault_mode == $past(pwdata[9:8]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("fault mode not stored"); // [R02]

    property p_gain_fixed;
        $past(resetn) |-> sense_gain_fixed_active == !$past(dynamic_sense_gain_enable);
    endproperty
    a_gain_fixed: assert property (p_gain_fixed) else $error("gain enable wrong"); // [R03]

    property p_seq_w1c;
        wr_cfg2 |=> regulator_sequencing_disable
            == ($past(regulator_sequencing_disable) && !$past(pwdata[24]));
    endproperty
    a_seq_w1c: assert property (p_seq_w1c) else $error("sequencing bit not w1c"); // [R06]

    property p_cfg2_fields;
        wr_cfg2 |=> {delay_comp_enable, delay_target_sel, regulator_current_limit_sel,
            regulator_voltage_sel, regulator_disable, low_side_min_on_sel}
            == {$past(pwdata[30:26]), $past(pwdata[23:17])};
    endproperty
    a_cfg2_fields: assert property (p_cfg2_fields) else $error("driver field lost"); // [R04] [R05] [R07] [R08] [R09] [R10]

    property p_algo_decode;
        s_setup_at(gate_driver_pkg::IDX_ALGO_ONE) ##1 s_access_seen
            |-> !pslverr && prdata == algo_config_one;
    endproperty
    a_algo_decode: assert property (p_algo_decode) else $error("algo word misdecoded"); // [R12]

    property p_reserved_zero;
        s_setup_at(gate_driver_pkg::IDX_CFG_SECOND) ##1 s_access_seen
            |-> !prdata[25] && prdata[16:0] == 17'h00000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // [R14]

    property p_deglitch;
        state_reg == gate_driver_pkg::FAULT_IDLE && oc_sync_reg
            |=> (state_reg != gate_driver_pkg::FAULT_IDLE)
                == ($past(deg_reg) == $past(deg_limit) - 1'b1);
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("trip timing wrong"); // [R13]

    property p_latched_hold;
        state_reg == gate_driver_pkg::FAULT_LATCHED && !fault_clear
            |=> state_reg == gate_driver_pkg::FAULT_LATCHED && outputs_disable;
    endproperty
    a_latched_hold: assert property (p_latched_hold) else $error("latched fault lost"); // [R15]

    property p_retry_end;
        state_reg == gate_driver_pkg::FAULT_RETRY
            && retry_reg == gate_driver_pkg::RETRY_CNT_W'(retry_cycles - 1)
            |=> !outputs_disable && status_reg[gate_driver_pkg::IRQ_RETRY_DONE];
    endproperty
    a_retry_end: assert property (p_retry_end) else $error("retry did not end"); // [R15]
endmodule

//--- verilog/gate_driver_pkg.sv
// constants for the gate-driver configuration register bank
// assumes a 40 MHz ref_clk and an APB3 master with 32-bit data
package gate_driver_pkg;
    localparam int unsigned CLK_MHZ = 40;

    // word indices; byte address is four times the index
    localparam logic [9:0] IDX_ALGO_ONE = 10'h0A0;
    localparam logic [9:0] IDX_ALGO_TWO = 10'h0A2;
    localparam logic [9:0] IDX_CFG_FIRST = 10'h0AC;
    localparam logic [9:0] IDX_CFG_SECOND = 10'h0AE;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0B0;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0B1;
    localparam logic [9:0] IDX_FAULT = 10'h0B2;

    // driver_config_first fields
    localparam int CFG1_PARITY = 31;
    localparam int CFG1_DEG_LSB = 12;
    localparam int CFG1_LVL = 10;
    localparam int CFG1_MODE_LSB = 8;
    localparam int CFG1_GAIN_LSB = 0;
    localparam logic [31:0] CFG1_WMASK = 32'h80003703;
    localparam logic [31:0] CFG1_RESET = 32'h00000100;

    // driver_config_second fields
    localparam int CFG2_PARITY = 31;
    localparam int CFG2_DCOMP = 30;
    localparam int CFG2_TDLY_LSB = 26;
    localparam int CFG2_SEQ = 24;
    localparam int CFG2_CL = 23;
    localparam int CFG2_VSEL_LSB = 21;
    localparam int CFG2_BDIS = 20;
    localparam int CFG2_MINON_LSB = 17;
    localparam logic [31:0] CFG2_RW_MASK = 32'hFCFE0000;
    localparam logic [31:0] CFG2_W1C_MASK = 32'h01000000;
    localparam logic [31:0] CFG2_RESET = 32'h01200000;

    localparam logic [31:0] ALGO1_WMASK = 32'h7FFFFFFF;
    localparam logic [31:0] ALGO2_WMASK = 32'hFFFFFFFF;
    localparam logic [31:0] ALGO_RESET = 32'h00000000;

    // fault handling
    localparam logic [1:0] MODE_LATCHED = 2'h0;
    localparam logic [1:0] MODE_RETRY = 2'h1;
    localparam int unsigned DEG_NS_0 = 200;
    localparam int unsigned DEG_NS_1 = 600;
    localparam int unsigned DEG_NS_2 = 1200;
    localparam int unsigned DEG_NS_3 = 1600;
    localparam int unsigned RETRY_MS = 500;
    localparam int unsigned RETRY_CYCLES = RETRY_MS * CLK_MHZ * 1000;
    localparam int DEG_CNT_W = 7;
    localparam int RETRY_CNT_W = 25;

    // interrupt and fault register bits
    localparam int IRQ_W = 2;
    localparam int IRQ_OC_FAULT = 0;
    localparam int IRQ_RETRY_DONE = 1;
    localparam int FAULT_ACTIVE_BIT = 0;
    localparam int FAULT_LATCHED_BIT = 1;
    localparam int FAULT_CLEAR_BIT = 0;

    typedef enum logic [1:0] {
        FAULT_IDLE = 2'b00,
        FAULT_LATCHED = 2'b01,
        FAULT_RETRY = 2'b10
    } fault_state_t;
endpackage

//--- dv/gate_driver_config_regs_test.sv
// self-checking bench for the gate-driver configuration register bank
// assumes the design's embedded assertions; drives APB and the trip pin directly
`timescale 1ns/1ps
module gate_driver_config_regs_test;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, outputs_disable, trip = 1'b0, dyn_gain = 1'b0;
    logic level_sel, gain_fixed, dcomp, seq_dis, cur_lim, reg_dis;
    logic [1:0] fault_mode, deg_sel, gain_sel, volt_sel;
    logic [3:0] tdly_sel;
    logic [2:0] min_on;
    logic [31:0] algo_one, algo_two, rd;
    logic err;
    int err_count = 0;
    int cmp_count = 0;
    int n;
    int deg_n [4] = '{8, 24, 48, 64};
    logic [1:0] modes [4] = '{2'h0, 2'h2, 2'h3, 2'h0};

    always #12.5 ref_clk = ~ref_clk;

    gate_driver_config_regs #(.retry_cycles(20)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .overcurrent_trip(trip),
        .dynamic_sense_gain_enable(dyn_gain), .overcurrent_level_sel(level_sel),
        .overcurrent_fault_mode(fault_mode), .overcurrent_deglitch_sel(deg_sel),
        .sense_amp_gain_sel(gain_sel), .sense_gain_fixed_active(gain_fixed),
        .delay_comp_enable(dcomp), .delay_target_sel(tdly_sel),
        .regulator_sequencing_disable(seq_dis), .regulator_current_limit_sel(cur_lim),
        .regulator_voltage_sel(volt_sel), .regulator_disable(reg_dis),
        .low_side_min_on_sel(min_on), .algo_config_one(algo_one),
        .algo_config_two(algo_two), .outputs_disable(outputs_disable), .irq(irq)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (pready !== 1'b1) begin
            err_count++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp);
        check({31'h0, err}, 32'h00000000);
    endtask

    task automatic wait_fault();
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (outputs_disable !== 1'b1 && n < 200);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(25 * 40000);
        err_count++;
        complete_run();
    end

    initial begin
        cyc(20);
        resetn <= 1'b1;
        rd_chk(12'h2B0, 32'h00000100);
        rd_chk(12'h2B8, 32'h01200000);
        check({fault_mode, volt_sel, seq_dis, level_sel}, 6'b01_01_1_0);
        rd_chk(12'h280, 32'h00000000);
        rd_chk(12'h288, 32'h00000000);
        apb(1'b1, 12'h2B0, 32'hFFFFFFFF);
        rd_chk(12'h2B0, 32'h80003703);
        check({level_sel, fault_mode, deg_sel, gain_sel}, 7'h7F);
        // gain code in force only with dynamic gain off
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 12'h2B0, 32'(k));
            dyn_gain <= k[0];
            cyc(2);
            check({30'h0, gain_sel}, 32'(k));
            check({31'h0, gain_fixed}, {31'h0, ~k[0]});
        end
        // bit 24 cleared by writing one, never set by a write; bit 25 reserved
        apb(1'b1, 12'h2B8, 32'hFFFFFFFF);
        rd_chk(12'h2B8, 32'hFCFE0000);
        check({dcomp, tdly_sel, seq_dis, cur_lim, volt_sel, reg_dis, min_on}, 13'h1F7F);
        apb(1'b1, 12'h2B8, 32'h25440000);
        rd_chk(12'h2B8, 32'h24440000);
        cyc(1);
        check({dcomp, tdly_sel, seq_dis, cur_lim, volt_sel, reg_dis, min_on}, 13'h0922);
        apb(1'b1, 12'h280, 32'hFFFFFFFF);
        apb(1'b1, 12'h288, 32'hA5C3F00F);
        rd_chk(12'h280, 32'h7FFFFFFF);
        rd_chk(12'h288, 32'hA5C3F00F);
        cyc(1);
        check(algo_one, 32'h7FFFFFFF);
        check(algo_two, 32'hA5C3F00F);
        // unlisted word only read, never written; it and an unaligned address are refused
        apb(1'b0, 12'h284, 32'h00000000);
        check({31'h0, err}, 32'h00000001);
        check(rd, 32'h00000000);
        apb(1'b0, 12'h281, 32'h00000000);
        check({31'h0, err}, 32'h00000001);
        rd_chk(12'h280, 32'h7FFFFFFF);
        apb(1'b1, 12'h2B0, 32'h00000000);
        apb(1'b1, 12'h2C4, 32'h00000001);
        trip <= 1'b1;
        cyc(5);
        trip <= 1'b0;
        cyc(20);
        check({31'h0, outputs_disable}, 32'h00000000);
        // every deglitch code with latching modes
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 12'h2B0, 32'(k << 12) | (32'(modes[k]) << 8));
            trip <= 1'b1;
            wait_fault();
            check({31'h0, (n >= deg_n[k]) && (n <= deg_n[k] + 4)}, 32'h00000001);
            trip <= 1'b0;
            cyc(40);
            check({31'h0, outputs_disable}, 32'h00000001);
            if (k == 0) begin
                check({31'h0, irq}, 32'h00000001);
                rd_chk(12'h2C8, 32'h00000003);
                rd_chk(12'h2C0, 32'h00000001);
                cyc(2);
                check({31'h0, irq}, 32'h00000000);
                rd_chk(12'h2C0, 32'h00000000);
            end
            apb(1'b1, 12'h2C8, 32'h00000001);
            cyc(2);
            check({31'h0, outputs_disable}, 32'h00000000);
        end
        rd_chk(12'h2C8, 32'h00000000);
        rd_chk(12'h2C0, 32'h00000001);
        // retry mode ends by itself, masked interrupt
        apb(1'b1, 12'h2C4, 32'h00000000);
        apb(1'b1, 12'h2B0, 32'h00000100);
        trip <= 1'b1;
        wait_fault();
        check({31'h0, outputs_disable}, 32'h00000001);
        trip <= 1'b0;
        check({31'h0, irq}, 32'h00000000);
        cyc(10);
        check({31'h0, outputs_disable}, 32'h00000001);
        cyc(20);
        check({31'h0, outputs_disable}, 32'h00000000);
        apb(1'b1, 12'h2C4, 32'h00000003);
        cyc(2);
        check({31'h0, irq}, 32'h00000001);
        rd_chk(12'h2C0, 32'h00000003);
        // reset in mid-run reloads the fields
        @(posedge ref_clk);
        resetn <= 1'b0;
        cyc(3);
        resetn <= 1'b1;
        rd_chk(12'h2B8, 32'h01200000);
        rd_chk(12'h288, 32'h00000000);
        check({31'h0, irq}, 32'h00000000);
        complete_run();
    end
endmodule
